/* rac_pkg.sv */
/*
 * rac_pkg: register indices, field positions, reset values and calibration
 * constants for the alarm date / subsecond / smooth calibration block.
 * Assumes one kernel clock domain and a plain strobe register port.
 */
package rac_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address on the register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_DATE_MATCH = 8'h1f;
  localparam logic [7:0] ADDR_ALARM_SUBSEC_HIGH = 8'h24;
  localparam logic [7:0] ADDR_ALARM_SUBSEC_LOW = 8'h25;
  localparam logic [7:0] ADDR_ALARM_SUBSEC_MASK = 8'h26;
  localparam logic [7:0] ADDR_CALIB_HIGH = 8'h2a;
  localparam logic [7:0] ADDR_CALIB_LOW = 8'h2b;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DATE_MASK_BIT_POS = 7;
  localparam int WEEKDAY_SELECT_POS = 6;
  localparam int DATE_TENS_HI = 5;
  localparam int DATE_TENS_LO = 4;
  localparam int DATE_UNITS_HI = 3;
  localparam int DATE_UNITS_LO = 0;
  localparam int PULSE_INSERT_POS = 7;
  localparam int EIGHT_SEC_POS = 6;
  localparam int SIXTEEN_SEC_POS = 5;
  localparam int MASK_COUNT_MSB_POS = 0;
  localparam logic [7:0] SUBSEC_HIGH_WMASK = 8'h7f;
  localparam logic [7:0] SUBSEC_MASK_WMASK = 8'h0f;
  localparam logic [7:0] CALIB_HIGH_WMASK = 8'he1;
  // ---------------------------------------------------------------
  // calibration cycle constants
  // ---------------------------------------------------------------
  localparam int CAL_CYCLE_BITS = 20;
  localparam int INSERT_PERIOD_BITS = 11;
  localparam logic [3:0] SUBSEC_WIDTH_FULL = 4'hf;
endpackage : rac_pkg

/* rac_bitrev.sv */
/*
 * rac_bitrev: reverses a vector, used to spread masked pulses evenly over
 * the calibration cycle. Pure combinational, no clock assumed.
 */
`timescale 1ns/100ps
module rac_bitrev #(
  parameter int W = 20
) (
  // vector in and out
  input wire logic [W-1:0] vec_in,
  output logic [W-1:0] vec_out
);
  // ---------------------------------------------------------------
  // reversal
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      vec_out[i] = vec_in[W-1-i];
    end
  end
endmodule : rac_bitrev

/* rac_top.sv */
/*
 * rac_top: alarm A date/weekday match, subsecond alarm compare and smooth
 * digital calibration, with their software registers.
 * Assumes the rest of the clock supplies calendar, prescaler and unlock
 * state on the kernel clock; rst_n_in is the power-on reset only.
 */
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
// Operation
// - date mask bit ignores date in alarm
// - weekday select makes units a weekday
// - date tens 5:4, units 3:0, BCD
// - 15-bit subsecond value compared with prescaler
// - unreachable subsecond value never fires
// - width zero fires on seconds-units increment
// - width n compares counter bits n-1:0
// - counter overflow bit never compared
// - insert one pulse every 2^11 pulses
// - mask count pulses out of 2^20
// - net added is 512*insert minus count
// - eight-second cycle forces count bits 1:0
// - sixteen-second cycle forces count bit 0
// - count msb at calib high bit 0
// - calib writes ignored while recal pending
// - writes need write-protection unlock
// - power-on reset only, to 0x00
module rac_top (
  // clock and power-on reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // rest of the clock, same kernel clock domain
  input wire logic unlocked_in,
  input wire logic init_mode_in,
  input wire logic alarm_a_enable_in,
  input wire logic alarm_write_allowed_flag_in,
  input wire logic recal_pending_flag_in,
  input wire logic [15:0] sync_prescaler_count_in,
  input wire logic seconds_units_inc_in,
  input wire logic [1:0] cal_date_tens_in,
  input wire logic [3:0] cal_date_units_in,
  input wire logic [2:0] cal_weekday_in,
  input wire logic time_fields_match_in,
  input wire logic kernel_tick_in,
  // results
  output logic alarm_a_match_out,
  output logic calendar_tick_out,
  output logic [8:0] pulse_mask_count_out
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] date_q;
  logic [7:0] ss_high_q;
  logic [7:0] ss_low_q;
  logic [7:0] ss_mask_q;
  logic [7:0] cal_high_q;
  logic [7:0] cal_low_q;
  logic [7:0] rdata_q;
  logic date_wr_ok;
  logic ss_wr_ok;
  logic cal_wr_ok;

  // locked or illegal writes are dropped, never stalled
  assign date_wr_ok = reg_wr_in && unlocked_in &&
    (init_mode_in || (!alarm_a_enable_in && alarm_write_allowed_flag_in));
  assign ss_wr_ok = reg_wr_in && unlocked_in &&
    (init_mode_in || !alarm_a_enable_in);
  assign cal_wr_ok = reg_wr_in && unlocked_in && !recal_pending_flag_in;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      date_q <= rac_pkg::RST_REG;
    end
    else if (date_wr_ok && reg_addr_in == rac_pkg::ADDR_ALARM_DATE_MATCH)
    begin
      date_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ss_high_q <= rac_pkg::RST_REG;
      ss_low_q <= rac_pkg::RST_REG;
      ss_mask_q <= rac_pkg::RST_REG;
    end
    else if (ss_wr_ok)
    begin
      if (reg_addr_in == rac_pkg::ADDR_ALARM_SUBSEC_HIGH)
      begin
        ss_high_q <= reg_wdata_in & rac_pkg::SUBSEC_HIGH_WMASK;
      end
      if (reg_addr_in == rac_pkg::ADDR_ALARM_SUBSEC_LOW)
      begin
        ss_low_q <= reg_wdata_in;
      end
      if (reg_addr_in == rac_pkg::ADDR_ALARM_SUBSEC_MASK)
      begin
        ss_mask_q <= reg_wdata_in & rac_pkg::SUBSEC_MASK_WMASK;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cal_high_q <= rac_pkg::RST_REG;
      cal_low_q <= rac_pkg::RST_REG;
    end
    else if (cal_wr_ok)
    begin
      if (reg_addr_in == rac_pkg::ADDR_CALIB_HIGH)
      begin
        cal_high_q <= reg_wdata_in & rac_pkg::CALIB_HIGH_WMASK;
      end
      if (reg_addr_in == rac_pkg::ADDR_CALIB_LOW)
      begin
        cal_low_q <= reg_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port: data one cycle after the strobe, zero elsewhere
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= rac_pkg::RST_REG;
    end
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        rac_pkg::ADDR_ALARM_DATE_MATCH: rdata_q <= date_q;
        rac_pkg::ADDR_ALARM_SUBSEC_HIGH: rdata_q <= ss_high_q;
        rac_pkg::ADDR_ALARM_SUBSEC_LOW: rdata_q <= ss_low_q;
        rac_pkg::ADDR_ALARM_SUBSEC_MASK: rdata_q <= ss_mask_q;
        rac_pkg::ADDR_CALIB_HIGH: rdata_q <= cal_high_q;
        rac_pkg::ADDR_CALIB_LOW: rdata_q <= cal_low_q;
        default: rdata_q <= rac_pkg::RST_REG;
      endcase
    end
    else
    begin
      rdata_q <= rac_pkg::RST_REG;
    end
  end
  assign reg_rdata_out = rdata_q;

  // ---------------------------------------------------------------
  // alarm compare
  // ---------------------------------------------------------------
  logic date_mask_bit;
  logic weekday_select;
  logic [1:0] date_tens;
  logic [3:0] date_units;
  logic date_ok;
  logic [3:0] subsecond_compare_width;
  logic [14:0] alarm_subsecond_value;
  logic [14:0] ss_cmp_mask;
  logic ss_ok;
  logic alarm_q;

  assign date_mask_bit = date_q[rac_pkg::DATE_MASK_BIT_POS];
  assign weekday_select = date_q[rac_pkg::WEEKDAY_SELECT_POS];
  assign date_tens = date_q[rac_pkg::DATE_TENS_HI:rac_pkg::DATE_TENS_LO];
  assign date_units = date_q[rac_pkg::DATE_UNITS_HI:rac_pkg::DATE_UNITS_LO];
  assign subsecond_compare_width = ss_mask_q[3:0];
  assign alarm_subsecond_value = {ss_high_q[6:0], ss_low_q};

  always_comb
  begin
    if (date_mask_bit)
    begin
      date_ok = 1'b1;
    end
    else if (weekday_select)
    begin
      date_ok = (date_units == {1'b0, cal_weekday_in});
    end
    else
    begin
      date_ok = (date_tens == cal_date_tens_in) && (date_units == cal_date_units_in);
    end
  end

  always_comb
  begin
    for (int i = 0; i < 15; i++)
    begin
      ss_cmp_mask[i] = (i < 32'(subsecond_compare_width));
    end
  end

  always_comb
  begin
    if (subsecond_compare_width == 4'h0)
    begin
      ss_ok = seconds_units_inc_in;
    end
    else
    begin
      // bit 15 of the counter is left out, so a counter with bit 15 set by a shift still matches
      // value beyond the divider never equals the counter, so never fires
      ss_ok = ((sync_prescaler_count_in[14:0] ^ alarm_subsecond_value)
               & ss_cmp_mask) == 15'h0000;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      alarm_q <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_a_enable_in && date_ok && ss_ok && time_fields_match_in;
    end
  end
  assign alarm_a_match_out = alarm_q;

  // ---------------------------------------------------------------
  // smooth calibration
  // ---------------------------------------------------------------
  logic pulse_insert_enable;
  logic eight_second_cycle;
  logic sixteen_second_cycle;
  logic [8:0] pulse_mask_count;
  logic [19:0] cyc_q;
  logic [19:0] cyc_rev;
  logic [19:0] cyc_view;
  logic mask_now;
  logic insert_now;
  logic [8:0] count_q;
  logic [19:0] mask_thr;
  logic ins_pend_q;

  assign pulse_insert_enable = cal_high_q[rac_pkg::PULSE_INSERT_POS];
  assign eight_second_cycle = cal_high_q[rac_pkg::EIGHT_SEC_POS];
  assign sixteen_second_cycle = cal_high_q[rac_pkg::SIXTEEN_SEC_POS];

  always_comb
  begin
    pulse_mask_count = {cal_high_q[rac_pkg::MASK_COUNT_MSB_POS], cal_low_q};
    if (eight_second_cycle)
    begin
      pulse_mask_count[1:0] = 2'b00;
    end
    else if (sixteen_second_cycle)
    begin
      pulse_mask_count[0] = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cyc_q <= 20'h0_0000;
    end
    else if (kernel_tick_in)
    begin
      cyc_q <= cyc_q + 20'h0_0001;
    end
  end

  rac_bitrev #(
    .W(rac_pkg::CAL_CYCLE_BITS)
  ) u_rev (
    .vec_in(cyc_q),
    .vec_out(cyc_rev)
  );

  // shorter cycles drop the low bits of the reversed count and mask a
  // quarter or half of the count per window, so every 32 s still loses
  // exactly the programmed count
  always_comb
  begin
    cyc_view = cyc_rev;
    mask_thr = {11'h000, pulse_mask_count};
    if (eight_second_cycle)
    begin
      cyc_view = {2'b00, cyc_rev[19:2]};
      mask_thr = {13'h0000, pulse_mask_count[8:2]};
    end
    else if (sixteen_second_cycle)
    begin
      cyc_view = {1'b0, cyc_rev[19:1]};
      mask_thr = {12'h000, pulse_mask_count[8:1]};
    end
  end

  // bit reversal spreads the masked slots evenly over the window
  assign mask_now = (cyc_view < mask_thr);
  // one slot in every 2^11 kernel ticks earns an extra calendar tick
  assign insert_now = pulse_insert_enable &&
    (cyc_q[rac_pkg::INSERT_PERIOD_BITS-1:0] == 11'h000);

  // the extra tick waits for the next cycle without a kernel tick;
  // a kernel tick held high on every core cycle would hold it back
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ins_pend_q <= 1'b0;
    end
    else if (kernel_tick_in && insert_now)
    begin
      ins_pend_q <= 1'b1;
    end
    else if (!kernel_tick_in)
    begin
      ins_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      calendar_tick_out <= 1'b0;
    end
    else
    begin
      calendar_tick_out <= (kernel_tick_in && !mask_now) ||
        (ins_pend_q && !kernel_tick_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_q <= 9'h000;
    end
    else
    begin
      count_q <= pulse_mask_count;
    end
  end
  assign pulse_mask_count_out = count_q;
endmodule : rac_top

/* rac_top_props.sv */
/*
 * rac_props: port-level checks of the alarm / calibration block.
 * Assumes it is bound to rac_top and sees only its ports.
 */
`timescale 1ns/100ps
module rac_props (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // status and results
  input wire logic unlocked_in,
  input wire logic recal_pending_flag_in,
  input wire logic alarm_a_enable_in,
  input wire logic time_fields_match_in,
  input wire logic kernel_tick_in,
  input wire logic alarm_a_match_out,
  input wire logic calendar_tick_out,
  input wire logic [8:0] pulse_mask_count_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // shadow of insert and cycle select bits, from accepted writes only
  // ---------------------------------------------------------------
  logic insert_q;
  logic eight_q;
  logic sixteen_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      insert_q <= 1'b0;
      eight_q <= 1'b0;
      sixteen_q <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == rac_pkg::ADDR_CALIB_HIGH && unlocked_in &&
             !recal_pending_flag_in)
    begin
      insert_q <= reg_wdata_in[rac_pkg::PULSE_INSERT_POS];
      eight_q <= reg_wdata_in[rac_pkg::EIGHT_SEC_POS];
      sixteen_q <= reg_wdata_in[rac_pkg::SIXTEEN_SEC_POS];
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence s_cal_refused;
    reg_wr_in && recal_pending_flag_in && reg_addr_in == rac_pkg::ADDR_CALIB_LOW;
  endsequence
  a_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  a_rd_unmapped: assert property (s_rd(8'h00) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rsv_high: assert property (s_rd(rac_pkg::ADDR_ALARM_SUBSEC_HIGH) |=> !reg_rdata_out[7])
    else $error("subsecond high bit 7 set");
  a_rsv_mask: assert property (s_rd(rac_pkg::ADDR_ALARM_SUBSEC_MASK) |=>
    reg_rdata_out[7:4] == 4'h0)
    else $error("mask reserved bits set");
  a_rsv_calib: assert property (s_rd(rac_pkg::ADDR_CALIB_HIGH) |=>
    reg_rdata_out[4:1] == 4'h0)
    else $error("calib high reserved bits set");
  a_tick_cause: assert property (calendar_tick_out && !$past(insert_q) |->
    $past(kernel_tick_in))
    else $error("calendar tick without kernel tick");
  a_ins_gap: assert property (calendar_tick_out && !$past(kernel_tick_in) |->
    $past(insert_q))
    else $error("extra calendar tick with insertion off");
  a_alarm_cause: assert property (alarm_a_match_out |->
    $past(alarm_a_enable_in) && $past(time_fields_match_in))
    else $error("alarm without enable and time match");
  // the count output lags the register by one cycle, so look two ahead
  a_cal_refused: assert property (s_cal_refused ##0 !$past(reg_wr_in) |->
    ##2 $stable(pulse_mask_count_out))
    else $error("calibration changed while pending");
  a_cnt_eight: assert property (eight_q |=> pulse_mask_count_out[1:0] == 2'b00)
    else $error("count low bits kept in eight-second cycle");
  a_cnt_sixteen: assert property (sixteen_q |=> !pulse_mask_count_out[0])
    else $error("count bit 0 kept in sixteen-second cycle");
endmodule : rac_props
bind rac_top rac_props u_props (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .unlocked_in, .recal_pending_flag_in, .alarm_a_enable_in,
  .time_fields_match_in, .kernel_tick_in, .alarm_a_match_out, .calendar_tick_out,
  .pulse_mask_count_out);

/* testbench.sv */
/*
 * testbench: directed checks of registers, write permissions, alarm
 * match and calibration count. Assumes rac_top and its bound checker.
 */
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic unl = 1'b0;
  logic init = 1'b0;
  logic en = 1'b0;
  logic wa = 1'b0;
  logic recal = 1'b0;
  logic [15:0] ssc = 16'h0000;
  logic sui = 1'b0;
  logic [1:0] dt = 2'h0;
  logic [3:0] du = 4'h0;
  logic [2:0] wd = 3'h0;
  logic tfm = 1'b0;
  logic kt = 1'b0;
  logic [7:0] rdata;
  logic am;
  logic ct;
  logic [8:0] pmc;
  int miscompares = 0;
  int n_checks = 0;
  initial forever #20 clk = ~clk;
  rac_top DUT (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .unlocked_in(unl),
    .init_mode_in(init), .alarm_a_enable_in(en), .alarm_write_allowed_flag_in(wa),
    .recal_pending_flag_in(recal), .sync_prescaler_count_in(ssc), .seconds_units_inc_in(sui),
    .cal_date_tens_in(dt), .cal_date_units_in(du), .cal_weekday_in(wd),
    .time_fields_match_in(tfm), .kernel_tick_in(kt), .alarm_a_match_out(am),
    .calendar_tick_out(ct), .pulse_mask_count_out(pmc));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic cmp_v(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_v
  task automatic cmp_f(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_f
  task automatic cmp_c(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_c
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read answer stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp_v({1'b0, rdata}, {1'b0, e});
  endtask : rd_chk
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h00);
    rd_chk(rac_pkg::ADDR_ALARM_SUBSEC_HIGH, 8'h00);
    rd_chk(rac_pkg::ADDR_ALARM_SUBSEC_LOW, 8'h00);
    rd_chk(rac_pkg::ADDR_ALARM_SUBSEC_MASK, 8'h00);
    rd_chk(rac_pkg::ADDR_CALIB_HIGH, 8'h00);
    rd_chk(rac_pkg::ADDR_CALIB_LOW, 8'h00);
    rd_chk(8'h00, 8'h00);
    @(posedge clk);
    kt <= 1'b1;
    @(posedge clk);
    kt <= 1'b0;
    #1;
    cmp_f(ct, 1'b1);
  endtask : t_reset
  task automatic t_protect;
    @(posedge clk);
    init <= 1'b1;
    wr_reg(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h25);
    rd_chk(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h00);
    @(posedge clk);
    unl <= 1'b1;
    init <= 1'b0;
    en <= 1'b1;
    wa <= 1'b1;
    wr_reg(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h25);
    rd_chk(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h00);
    wr_reg(rac_pkg::ADDR_ALARM_SUBSEC_LOW, 8'h12);
    rd_chk(rac_pkg::ADDR_ALARM_SUBSEC_LOW, 8'h00);
    @(posedge clk);
    en <= 1'b0;
    wa <= 1'b0;
    wr_reg(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h25);
    rd_chk(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h00);
    @(posedge clk);
    wa <= 1'b1;
    wr_reg(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h25);
    rd_chk(rac_pkg::ADDR_ALARM_DATE_MATCH, 8'h25);
    wr_reg(rac_pkg::ADDR_ALARM_SUBSEC_HIGH, 8'hff);
    rd_chk(rac_pkg::ADDR_ALARM_SUBSEC_HIGH, 8'h7f);
    wr_reg(rac_pkg::ADDR_ALARM_SUBSEC_MASK, 8'hff);
    rd_chk(rac_pkg::ADDR_ALARM_SUBSEC_MASK, 8'h0f);
  endtask : t_protect
  task automatic t_calib;
    @(posedge clk);
    recal <= 1'b1;
    wr_reg(rac_pkg::ADDR_CALIB_LOW, 8'hff);
    rd_chk(rac_pkg::ADDR_CALIB_LOW, 8'h00);
    @(posedge clk);
    recal <= 1'b0;
    wr_reg(rac_pkg::ADDR_CALIB_LOW, 8'hff);
    // eight and sixteen never set together
    wr_reg(rac_pkg::ADDR_CALIB_HIGH, 8'hc1);
    rd_chk(rac_pkg::ADDR_CALIB_HIGH, 8'hc1);
    cmp_v(pmc, 9'h1fc);
    wr_reg(rac_pkg::ADDR_CALIB_HIGH, 8'h21);
    @(posedge clk);
    #1;
    cmp_v(pmc, 9'h1fe);
    wr_reg(rac_pkg::ADDR_CALIB_HIGH, 8'h81);
    @(posedge clk);
    #1;
    cmp_v(pmc, 9'h1ff);
  endtask : t_calib
  // any 2048 kernel ticks in a row hold exactly one insert slot
  task automatic t_insert;
    logic [15:0] ticks;
    ticks = 16'h0000;
    wr_reg(rac_pkg::ADDR_CALIB_LOW, 8'h00);
    wr_reg(rac_pkg::ADDR_CALIB_HIGH, 8'h80);
    for (int i = 0; i < 4098; i++)
    begin
      @(posedge clk);
      kt <= (i < 4096) ? ~kt : 1'b0;
      #1;
      if (ct === 1'b1)
      begin
        ticks = ticks + 16'h0001;
      end
    end
    cmp_c(ticks, 16'h0801);
  endtask : t_insert
  // program alarm registers, present calendar state, check match
  task automatic al(input logic [7:0] d, input logic [3:0] w, input logic [14:0] s,
    input logic [15:0] c, input logic [3:0] u, input logic [2:0] k, input logic i,
    input logic f, input logic e);
    wr_reg(rac_pkg::ADDR_ALARM_DATE_MATCH, d);
    wr_reg(rac_pkg::ADDR_ALARM_SUBSEC_HIGH, {1'b0, s[14:8]});
    wr_reg(rac_pkg::ADDR_ALARM_SUBSEC_LOW, s[7:0]);
    wr_reg(rac_pkg::ADDR_ALARM_SUBSEC_MASK, {4'h0, w});
    @(posedge clk);
    ssc <= c;
    dt <= 2'h2;
    du <= u;
    wd <= k;
    sui <= i;
    tfm <= f;
    @(posedge clk);
    #1;
    cmp_f(am, e);
  endtask : al
  task automatic t_alarm;
    @(posedge clk);
    init <= 1'b1;
    en <= 1'b1;
    al(8'h25, 4'h0, 15'h0000, 16'h0000, 4'h5, 3'h0, 1'b1, 1'b1, 1'b1);
    al(8'h25, 4'h0, 15'h0000, 16'h0000, 4'h6, 3'h0, 1'b1, 1'b1, 1'b0);
    al(8'ha5, 4'h0, 15'h0000, 16'h0000, 4'h6, 3'h0, 1'b1, 1'b1, 1'b1);
    al(8'h43, 4'h0, 15'h0000, 16'h0000, 4'h9, 3'h3, 1'b1, 1'b1, 1'b1);
    al(8'h43, 4'h0, 15'h0000, 16'h0000, 4'h3, 3'h4, 1'b1, 1'b1, 1'b0);
    al(8'h25, 4'h0, 15'h0000, 16'h0000, 4'h5, 3'h0, 1'b0, 1'b1, 1'b0);
    al(8'h80, 4'h4, 15'h0005, 16'h0015, 4'h0, 3'h0, 1'b0, 1'b1, 1'b1);
    al(8'h80, 4'h4, 15'h0005, 16'h0016, 4'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    al(8'h80, 4'hf, 15'h1234, 16'h9234, 4'h0, 3'h0, 1'b0, 1'b1, 1'b1);
    al(8'h80, 4'hf, 15'h1234, 16'h1234, 4'h0, 3'h0, 1'b0, 1'b1, 1'b1);
    al(8'h80, 4'hf, 15'h1234, 16'h0234, 4'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    al(8'h80, 4'hf, 15'h7fff, 16'h3fff, 4'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    al(8'h80, 4'h0, 15'h0000, 16'h0000, 4'h0, 3'h0, 1'b1, 1'b0, 1'b0);
  endtask : t_alarm
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_protect;
    t_calib;
    t_insert;
    t_alarm;
    print_verdict;
  end
  // run is about 4,300 cycles; the limit of 10,000 allows over twice that
  initial
  begin
    #400000;
    miscompares++;
    print_verdict;
  end
endmodule : testbench
